// File: rtl/dmct_pkg.sv
// Purpose: Shared constants for the dual mode compare timer.
// Assumes: An 8-bit peripheral bus with a small register index.
// Notes:   Offsets, bit positions, reset values and tick divisors live here.
`default_nettype none

package dmct_pkg;

  // Register index width and register indexes on the byte bus.
  localparam int          ADDR_W       = 3;
  localparam logic [2:0]  ADDR_CNT_HI  = 3'h0;
  localparam logic [2:0]  ADDR_CNT_LO  = 3'h1;
  localparam logic [2:0]  ADDR_CMP_HI  = 3'h2;
  localparam logic [2:0]  ADDR_CMP_LO  = 3'h3;
  localparam logic [2:0]  ADDR_CTRL    = 3'h4;
  localparam logic [2:0]  ADDR_CSR     = 3'h5;
  localparam logic [2:0]  ADDR_CKSTP   = 3'h6;

  // Values after reset, and the fixed read value of timer_control.
  localparam logic [15:0] CNT_RST      = 16'h0000;
  localparam logic [15:0] CMP_RST      = 16'hFFFF;
  localparam logic [7:0]  CTRL_RST     = 8'h00;
  localparam logic [7:0]  CSR_RST      = 8'h00;
  localparam logic [7:0]  CKSTP_RST    = 8'hFF;
  localparam logic [7:0]  CTRL_READ    = 8'h00;

  // Field positions of timer_control.
  localparam int          CTRL_OUT_HI  = 7;
  localparam int          CTRL_SEL_HI  = 4;
  localparam int          CTRL_OUT_LO  = 3;
  localparam int          CTRL_SEL_LO  = 0;
  localparam int          SEL_W        = 3;

  // Field positions of timer_ctrl_status.
  localparam int          CSR_WRAP_HI  = 7;
  localparam int          CSR_MATCH_HI = 6;
  localparam int          CSR_WIE_HI   = 5;
  localparam int          CSR_CLR_HI   = 4;
  localparam int          CSR_WRAP_LO  = 3;
  localparam int          CSR_MATCH_LO = 2;
  localparam int          CSR_WIE_LO   = 1;
  localparam int          CSR_CLR_LO   = 0;

  // Timer standby control bit in peripheral_clock_stop_one.
  localparam int          CKSTP_TIMER  = 2;

  // Prescaler masks: a tick fires when the masked count is all ones.
  localparam int          PRE_W        = 5;
  localparam logic [4:0]  PRE_MASK_32  = 5'h1F;
  localparam logic [4:0]  PRE_MASK_16  = 5'h0F;
  localparam logic [4:0]  PRE_MASK_4   = 5'h03;
  localparam logic [1:0]  SUB_DIV_LAST = 2'h3;

  // Tick source codes of one clock-select field.
  typedef enum logic [2:0] {
    TICK_ALT  = 3'b000,
    TICK_NA   = 3'b011,
    TICK_D32  = 3'b100,
    TICK_D16  = 3'b101,
    TICK_D4   = 3'b110,
    TICK_SUB4 = 3'b111
  } dmct_tick_e;

endpackage

`default_nettype wire

// File: rtl/dmct_sync.sv
// Purpose: Two flip-flop synchroniser for pins from outside the clock domain.
// Assumes: Each bit is an independent level; no bus coherency is needed.
// Notes:   Only the second stage is visible outside this module.
`default_nettype none

module dmct_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,     // Sampling clock.
  input  wire logic         rst,     // Asynchronous reset, active high.
  input  wire logic [W-1:0] async_i, // Levels from another domain.
  output logic      [W-1:0] sync_o   // Synchronised levels.
);

  logic [W-1:0] meta_q; // First stage, read only by the second stage.

  // Refuse a zero width at elaboration.
  if (W < 1) begin : g_chk
    $error("dmct_sync needs W of at least one.");
  end

  // The two stages give a metastable first sample a full cycle to settle.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule

`default_nettype wire

// File: rtl/dmct_half.sv
// Purpose: One counter half with load, clear, equality and wrap detection.
// Assumes: Tick, clear and load are one-cycle pulses on the same clock.
// Notes:   Match timing is decided by the parent; this half only reports equality.
`default_nettype none

module dmct_half
  import dmct_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         clk,    // System clock.
  input  wire logic         rst,    // Asynchronous reset, active high.
  input  wire logic         tick,   // Count enable pulse.
  input  wire logic         clr,    // Clear to zero, pulse.
  input  wire logic         ld,     // Software load, pulse.
  input  wire logic [W-1:0] ld_val, // Value for a software load.
  input  wire logic [W-1:0] cmp,    // Compare byte.
  output logic      [W-1:0] cnt,    // Current count, from a flip-flop.
  output logic              eq,     // Count equals compare.
  output logic              wrap    // Wrap from all ones to zero on this tick.
);

  // A half narrower than two bits cannot hold a meaningful compare.
  if (W < 2) begin : g_chk
    $error("dmct_half needs W of at least two.");
  end

  // Equality is combinational so the parent can judge the last equal state.
  assign eq   = (cnt == cmp);
  // A write or a clear in the same cycle suppresses the wrap event.
  assign wrap = tick & (&cnt) & ~clr & ~ld;

  // Software load wins over clear, clear wins over counting.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= CNT_RST[W-1:0];
    end else if (ld) begin
      cnt <= ld_val;
    end else if (clr) begin
      cnt <= '0;
    end else if (tick) begin
      cnt <= cnt + 1'b1;
    end
  end

endmodule

`default_nettype wire

// File: rtl/dmct_top.sv
// Purpose: Dual mode compare timer: one 16-bit or two 8-bit up-counters.
// Assumes: A CPU on an 8-bit bus with one-cycle read and write strobes.
// Notes:   16-bit counter bytes and compare writes pass through one holding latch.
//
// Notes on behaviour
// - Low wrap sets lower wrap flag.
// - Low equality sets lower match flag.
// - Lower wrap interrupt enable at bit one.
// - Lower clear-on-match clears low counter.
// - Clock stop bit two low stops timer.
// - In 8-bit mode bytes go direct.
// - Upper write latched, lower write loads both.
// - Upper counter read latches lower byte.
// - Compare reads return bytes directly.
// - Upper select MSB chooses 16 or 8-bit.
// - Reset values for counter, compare, controls.
// - 16-bit match: flag, interrupt, toggle, clear.
// - 16-bit wrap sets upper flag, maybe interrupt.
// - 8-bit half match: flag, toggle, interrupt, clear.
// - 8-bit half wrap: flag, gated interrupt.
// - Four internal tick sources per select.
// - Event pin edge chosen by edge select.
// - Toggle pin holds level, inverts on match.
// - Match fires on leaving the equal value.
// - Select codes: cascade, unavailable, dividers, event.
// - Level bit write drives pin at once.
// - Flag bits accept only clearing zeros.
`default_nettype none

module dmct_top
  import dmct_pkg::*;
(
  input  wire logic              mclk,              // System clock, 125 MHz.
  input  wire logic              sys_rst,           // Asynchronous reset, active high.
  input  wire logic [ADDR_W-1:0] bus_addr,          // Register index.
  input  wire logic              bus_wr,            // Write strobe, one cycle.
  input  wire logic              bus_rd,            // Read strobe, one cycle.
  input  wire logic [7:0]        bus_wdata,         // Write data byte.
  output logic      [7:0]        bus_rdata,         // Read data, valid the cycle after bus_rd.
  input  wire logic              sub_clk_pin,       // Sub-clock from outside the domain.
  input  wire logic              event_input_pin,   // External event pin.
  input  wire logic              event_edge_select, // One counts rising edges, zero falling.
  input  wire logic              upper_irq_enable,  // Upper interrupt enable from outside.
  input  wire logic              lower_irq_enable,  // Lower interrupt enable from outside.
  output logic                   upper_toggle_pin,  // Upper toggle output.
  output logic                   lower_toggle_pin,  // Lower toggle output.
  output logic                   upper_irq_req,     // Upper interrupt request pulse.
  output logic                   lower_irq_req      // Lower interrupt request pulse.
);

  logic [7:0]       ctrl_q;     // timer_control.
  logic [7:0]       csr_q;      // timer_ctrl_status.
  logic [7:0]       ckstp_q;    // peripheral_clock_stop_one.
  logic [15:0]      cmp_q;      // timer_compare_value.
  logic [7:0]       temp_q;     // Holding latch for 16-bit byte pairs.
  logic [3:0]       arm_q;      // Flags seen as one by a status read.
  logic [PRE_W-1:0] pre_q;      // Free prescaler on the system clock.
  logic [1:0]       sub_div_q;  // Sub-clock edge divider.
  logic             sub_d_q;    // Delayed synchronised sub-clock.
  logic             ev_d_q;     // Delayed synchronised event pin.
  logic [1:0]       pins_s;     // Synchronised sub-clock and event pin.
  logic [7:0]       cnt_hi;     // Upper counter half.
  logic [7:0]       cnt_lo;     // Lower counter half.
  logic             eq_hi;      // Upper half equals its compare byte.
  logic             eq_lo;      // Lower half equals its compare byte.
  logic             wrap_hi;    // Upper half wraps on this cycle.
  logic             wrap_lo;    // Lower half wraps on this cycle.

  // Bus decode, one strobe per register.
  logic wr_cnt_hi, wr_cnt_lo, wr_cmp_hi, wr_cmp_lo, wr_ctrl, wr_csr, wr_ckstp;
  logic rd_cnt_hi, rd_csr;
  assign wr_cnt_hi = bus_wr & (bus_addr == ADDR_CNT_HI);
  assign wr_cnt_lo = bus_wr & (bus_addr == ADDR_CNT_LO);
  assign wr_cmp_hi = bus_wr & (bus_addr == ADDR_CMP_HI);
  assign wr_cmp_lo = bus_wr & (bus_addr == ADDR_CMP_LO);
  assign wr_ctrl   = bus_wr & (bus_addr == ADDR_CTRL);
  assign wr_csr    = bus_wr & (bus_addr == ADDR_CSR);
  assign wr_ckstp  = bus_wr & (bus_addr == ADDR_CKSTP);
  assign rd_cnt_hi = bus_rd & (bus_addr == ADDR_CNT_HI);
  assign rd_csr    = bus_rd & (bus_addr == ADDR_CSR);

  // Mode and run state.
  logic       mode8;   // One when the halves run as two 8-bit counters.
  logic       run;     // Zero while the timer is in module standby.
  logic [2:0] sel_hi;  // Upper tick select code.
  logic [2:0] sel_lo;  // Lower tick select code.
  assign mode8  = ctrl_q[CTRL_SEL_HI+SEL_W-1];
  assign run    = ckstp_q[CKSTP_TIMER];
  assign sel_hi = ctrl_q[CTRL_SEL_HI +: SEL_W];
  assign sel_lo = ctrl_q[CTRL_SEL_LO +: SEL_W];

  // The sub-clock and the event pin come from outside and are synchronised first.
  dmct_sync #(.W(2)) u_sync (
    .clk     (mclk),
    .rst     (sys_rst),
    .async_i ({sub_clk_pin, event_input_pin}),
    .sync_o  (pins_s)
  );

  // Delayed copies for edge detection on the synchronised levels.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sub_d_q <= 1'b0;
      ev_d_q  <= 1'b0;
    end else begin
      sub_d_q <= pins_s[1];
      ev_d_q  <= pins_s[0];
    end
  end

  // Free prescaler; it runs through standby so that ticks stay evenly spaced.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 1'b1;
    end
  end

  // Sub-clock rising edges divided by four; the sub-clock must be slower than mclk.
  logic sub_rise;
  assign sub_rise = pins_s[1] & ~sub_d_q;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sub_div_q <= '0;
    end else if (sub_rise) begin
      sub_div_q <= sub_div_q + 1'b1;
    end
  end

  // Tick enables from the dividers, each one mclk cycle long.
  logic en32, en16, en4, ensub, ev_edge;
  assign en32    = (pre_q & PRE_MASK_32) == PRE_MASK_32;
  assign en16    = (pre_q & PRE_MASK_16) == PRE_MASK_16;
  assign en4     = (pre_q & PRE_MASK_4) == PRE_MASK_4;
  assign ensub   = sub_rise & (sub_div_q == SUB_DIV_LAST);
  // Two-flop sampling means events shorter than one clock can be missed.
  assign ev_edge = event_edge_select ? (pins_s[0] & ~ev_d_q)
                                     : (~pins_s[0] & ev_d_q);

  // Chooses a tick from a select code; alt is used for codes 000 to 010, below TICK_NA.
  function automatic logic pick_tick(input logic [2:0] code, input logic alt);
    logic t;
    t = 1'b0;
    unique case (code)
      TICK_D32:  t = en32;
      TICK_D16:  t = en16;
      TICK_D4:   t = en4;
      TICK_SUB4: t = ensub;
      TICK_NA:   t = 1'b0;
      default:   t = alt;
    endcase
    return t;
  endfunction

  // Lower half: divider or event pin. Upper half: divider or the lower wrap.
  logic tick_lo, tick_hi;
  assign tick_lo = run & pick_tick(sel_lo, ev_edge);
  assign tick_hi = mode8 ? (run & pick_tick(sel_hi, 1'b0))
                         : wrap_lo;

  // Loads: in 16-bit mode the upper byte comes from the latch at the lower write.
  logic       ld_hi, cmpw_hi;
  logic [7:0] ld_hi_val;
  assign ld_hi     = mode8 ? wr_cnt_hi : wr_cnt_lo;
  assign ld_hi_val = mode8 ? bus_wdata : temp_q;
  assign cmpw_hi   = mode8 ? wr_cmp_hi : wr_cmp_lo;

  // A match fires on the tick that leaves the equal value; a compare write voids it.
  logic match_lo, match_hi8, match16, match_hi;
  assign match_lo  = tick_lo & eq_lo & ~wr_cmp_lo;
  assign match16   = match_lo & eq_hi & ~cmpw_hi;
  assign match_hi8 = tick_hi & eq_hi & ~cmpw_hi;
  assign match_hi  = mode8 ? match_hi8 : match16;

  // Clear on match: in 16-bit mode the upper clear bit clears both halves.
  logic clr_lo, clr_hi;
  assign clr_lo = mode8 ? (match_lo & csr_q[CSR_CLR_LO])
                        : (match16 & csr_q[CSR_CLR_HI]);
  assign clr_hi = match_hi & csr_q[CSR_CLR_HI];

  dmct_half #(.W(8)) u_lo (
    .clk    (mclk),
    .rst    (sys_rst),
    .tick   (tick_lo),
    .clr    (clr_lo),
    .ld     (wr_cnt_lo),
    .ld_val (bus_wdata),
    .cmp    (cmp_q[7:0]),
    .cnt    (cnt_lo),
    .eq     (eq_lo),
    .wrap   (wrap_lo)
  );

  dmct_half #(.W(8)) u_hi (
    .clk    (mclk),
    .rst    (sys_rst),
    .tick   (tick_hi),
    .clr    (clr_hi),
    .ld     (ld_hi),
    .ld_val (ld_hi_val),
    .cmp    (cmp_q[15:8]),
    .cnt    (cnt_hi),
    .eq     (eq_hi),
    .wrap   (wrap_hi)
  );

  // Compare register, written per byte or as a latched pair.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cmp_q <= CMP_RST;
    end else begin
      if (cmpw_hi) begin
        cmp_q[15:8] <= ld_hi_val;
      end
      if (wr_cmp_lo) begin
        cmp_q[7:0] <= bus_wdata;
      end
    end
  end

  // Holding latch: upper writes park data, upper counter reads park the lower byte.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      temp_q <= 8'h00;
    end else if (wr_cnt_hi | wr_cmp_hi) begin
      temp_q <= bus_wdata;
    end else if (rd_cnt_hi) begin
      temp_q <= cnt_lo;
    end
  end

  // Control and standby registers are plain storage.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q  <= CTRL_RST;
      ckstp_q <= CKSTP_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= bus_wdata;
      end
      if (wr_ckstp) begin
        ckstp_q <= bus_wdata;
      end
    end
  end

  // Flag events, index order matches the arm bits: wrap hi, match hi, wrap lo, match lo.
  logic [3:0] fset, fclr, fcur, wzero;
  assign fset  = {wrap_hi, match_hi, wrap_lo, match_lo};
  assign fcur  = {csr_q[CSR_WRAP_HI], csr_q[CSR_MATCH_HI], csr_q[CSR_WRAP_LO], csr_q[CSR_MATCH_LO]};
  assign wzero = ~{bus_wdata[CSR_WRAP_HI], bus_wdata[CSR_MATCH_HI],
                   bus_wdata[CSR_WRAP_LO], bus_wdata[CSR_MATCH_LO]};
  // Only a zero written after a read that showed one clears; ones are ignored.
  assign fclr  = {4{wr_csr}} & wzero & arm_q;

  // Arming: a status read remembers which flags were seen set.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      arm_q <= 4'h0;
    end else if (rd_csr) begin
      arm_q <= fcur;
    end else if (wr_csr) begin
      arm_q <= 4'h0;
    end
  end

  // Status register: set wins over clear, so no event is lost to a racing clear.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      csr_q <= CSR_RST;
    end else begin
      csr_q[CSR_WRAP_HI]  <= fset[3] | (fcur[3] & ~fclr[3]);
      csr_q[CSR_MATCH_HI] <= fset[2] | (fcur[2] & ~fclr[2]);
      csr_q[CSR_WRAP_LO]  <= fset[1] | (fcur[1] & ~fclr[1]);
      csr_q[CSR_MATCH_LO] <= fset[0] | (fcur[0] & ~fclr[0]);
      if (wr_csr) begin
        csr_q[CSR_WIE_HI] <= bus_wdata[CSR_WIE_HI];
        csr_q[CSR_CLR_HI] <= bus_wdata[CSR_CLR_HI];
        csr_q[CSR_WIE_LO] <= bus_wdata[CSR_WIE_LO];
        csr_q[CSR_CLR_LO] <= bus_wdata[CSR_CLR_LO];
      end
    end
  end

  // Toggle pins: a control write drives the level at once and beats a same-cycle match.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      upper_toggle_pin <= 1'b0;
      lower_toggle_pin <= 1'b0;
    end else if (wr_ctrl) begin
      upper_toggle_pin <= bus_wdata[CTRL_OUT_HI];
      lower_toggle_pin <= bus_wdata[CTRL_OUT_LO];
    end else begin
      if (match_hi) begin
        upper_toggle_pin <= ~upper_toggle_pin;
      end
      // The lower pin is left alone in 16-bit mode, where it serves no purpose.
      if (match_lo & mode8) begin
        lower_toggle_pin <= ~lower_toggle_pin;
      end
    end
  end

  // Interrupt requests: one-cycle pulses gated by the outside enables.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      upper_irq_req <= 1'b0;
      lower_irq_req <= 1'b0;
    end else begin
      upper_irq_req <= upper_irq_enable &
                       (match_hi | (wrap_hi & csr_q[CSR_WIE_HI]));
      lower_irq_req <= lower_irq_enable &
                       ((match_lo & mode8) | (wrap_lo & csr_q[CSR_WIE_LO]));
    end
  end

  // Read data is registered; reads have no side effect except the latch copy and the status read arming.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_rdata <= 8'h00;
    end else if (bus_rd) begin
      unique case (bus_addr)
        ADDR_CNT_HI: bus_rdata <= cnt_hi;
        ADDR_CNT_LO: bus_rdata <= mode8 ? cnt_lo : temp_q;
        ADDR_CMP_HI: bus_rdata <= cmp_q[15:8];
        ADDR_CMP_LO: bus_rdata <= cmp_q[7:0];
        ADDR_CTRL:   bus_rdata <= CTRL_READ;
        ADDR_CSR:    bus_rdata <= csr_q;
        ADDR_CKSTP:  bus_rdata <= ckstp_q;
        default:     bus_rdata <= 8'h00;
      endcase
    end
  end

endmodule

`default_nettype wire

// File: sim/dmct_assertions.sv
// Purpose: Port-level assertions for the dual mode compare timer.
// Assumes: Only the top ports are visible, so registers are judged by their effects.
// Notes:   Helper flops keep one-cycle-old causes, so no $past of an expression is needed.
`default_nettype none

module dmct_assertions
  import dmct_pkg::*;
(
  input wire logic              mclk, sys_rst, bus_wr, bus_rd, sub_clk_pin, event_input_pin,  // Inputs.
  input wire logic              event_edge_select, upper_irq_enable, lower_irq_enable,        // Inputs.
  input wire logic              upper_toggle_pin, lower_toggle_pin, upper_irq_req, lower_irq_req, // Outputs.
  input wire logic [ADDR_W-1:0] bus_addr,                                                     // Index.
  input wire logic [7:0]        bus_wdata, bus_rdata                                          // Bytes.
);
  timeunit 1ns;
  timeprecision 1ps;

  logic       ctrl_wr_q, ien_hi_q, ien_lo_q;  // Causes seen one edge ago.
  logic [7:0] wd_q;                           // Byte of that edge.

  // A pin change is caused at the edge before it shows, so its causes are delayed alike.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      {ctrl_wr_q, ien_hi_q, ien_lo_q, wd_q} <= '0;
    end else begin
      {ctrl_wr_q, ien_hi_q, ien_lo_q, wd_q} <= {bus_wr && bus_addr == ADDR_CTRL, upper_irq_enable,
                                               lower_irq_enable, bus_wdata};
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  sequence ctrl_wr_s;
    bus_wr && bus_addr == ADDR_CTRL;
  endsequence
  sequence pin_hi_s;
    $changed(upper_toggle_pin) && !ctrl_wr_q && ien_hi_q;
  endsequence
  sequence pin_lo_s;
    $changed(lower_toggle_pin) && !ctrl_wr_q && ien_lo_q;
  endsequence

  rst_out_a: assert property ($fell(sys_rst) |-> bus_rdata == 8'h00 && !upper_irq_req && !lower_irq_req
    && !upper_toggle_pin && !lower_toggle_pin) else $error("outputs not idle after reset");
  rd_hold_a: assert property (!bus_rd |=> $stable(bus_rdata))
    else $error("read data moved without a read");
  ctrl_rd_a: assert property (bus_rd && (bus_addr == ADDR_CTRL || bus_addr == 3'h7) |=> bus_rdata == 8'h00)
    else $error("control or unmapped read not zero");
  level_wr_a: assert property (ctrl_wr_s |=> upper_toggle_pin == wd_q[CTRL_OUT_HI]
    && lower_toggle_pin == wd_q[CTRL_OUT_LO]) else $error("level write not on pins");
  hi_match_a: assert property (pin_hi_s |-> upper_irq_req)
    else $error("upper toggle without request");
  lo_match_a: assert property (pin_lo_s |-> lower_irq_req)
    else $error("lower toggle without request");
  hi_pulse_a: assert property (upper_irq_req |=> !upper_irq_req)
    else $error("upper request longer than one cycle");
  hi_gate_a: assert property (!upper_irq_enable |=> !upper_irq_req)
    else $error("upper request while disabled");
  lo_gate_a: assert property (!lower_irq_enable |=> !lower_irq_req)
    else $error("lower request while disabled");
endmodule

bind dmct_top dmct_assertions chk (.mclk, .sys_rst, .bus_wr, .bus_rd, .sub_clk_pin, .event_input_pin,
  .event_edge_select, .upper_irq_enable, .lower_irq_enable, .upper_toggle_pin, .lower_toggle_pin,
  .upper_irq_req, .lower_irq_req, .bus_addr, .bus_wdata, .bus_rdata);

`default_nettype wire

// File: sim/dmct_cpu_model.sv
// Purpose: CPU side of the byte bus that reaches the timer registers.
// Assumes: One strobe cycle per access; read data is taken at the taking edge.
// Notes:   An idle bus shows inverted address and data, never the last value.
`default_nettype none

module dmct_cpu_model
  import dmct_pkg::*;
(
  input  wire logic              mclk,      // System clock.
  input  wire logic [7:0]        bus_rdata, // Read byte.
  output var  logic [ADDR_W-1:0] bus_addr,  // Register index.
  output var  logic              bus_wr,    // Write strobe.
  output var  logic              bus_rd,    // Read strobe.
  output var  logic [7:0]        bus_wdata  // Write byte.
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {bus_wr, bus_rd, bus_addr, bus_wdata} = '0;
  end

  // Strobe and qualifiers hold until the edge that takes them.
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge mclk);
    #1 {bus_wr, bus_rd, bus_addr, bus_wdata} = {w, ~w, a, d};
    @(posedge mclk);
    #1 q = bus_rdata;
    {bus_wr, bus_rd, bus_addr, bus_wdata} = {2'h0, ~a, ~d};
  endtask

  // Upper byte goes first, so the holding latch pairs the two halves.
  task automatic wr16(input logic [2:0] a, input logic [15:0] v);
    logic [7:0] q;
    acc(1'b1, a, v[15:8], q);
    acc(1'b1, a + 3'h1, v[7:0], q);
  endtask

  task automatic rd16(input logic [2:0] a, output logic [15:0] v);
    acc(1'b0, a, 8'h00, v[15:8]);
    acc(1'b0, a + 3'h1, 8'h00, v[7:0]);
  endtask
endmodule

`default_nettype wire

// File: sim/dual_mode_compare_timer_tb_top.sv
// Purpose: Self-checking bench for the dual mode compare timer.
// Assumes: Every register access goes through the bus model.
// Notes:   Counts after a timed run allow one tick of slack for prescaler phase.
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; $display("BAD %0t got %h exp %h", $time, g, e); end end

module dual_mode_compare_timer_tb_top
  import dmct_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              mclk = 1'b0, sys_rst = 1'b1, sub_clk_pin = 1'b0, event_input_pin = 1'b0;
  logic              event_edge_select = 1'b1, upper_irq_enable = 1'b0, lower_irq_enable = 1'b0;
  logic              bus_wr, bus_rd, upper_toggle_pin, lower_toggle_pin, upper_irq_req, lower_irq_req;
  logic [ADDR_W-1:0] bus_addr;
  logic [7:0]        bus_wdata, bus_rdata, q;
  logic [15:0]       v, rnd = 16'h0011;
  int                bad_count = 0, n_tests = 0, n;
  logic [7:0]        rstv [8] = '{CNT_RST[15:8], CNT_RST[7:0], CMP_RST[15:8], CMP_RST[7:0], 8'h00, 8'h00,
                                  8'hFF, 8'h00};

  always #4 mclk = ~mclk;
  // Sub-clock runs slower than a quarter of the system clock.
  always #32 sub_clk_pin = ~sub_clk_pin;

  dmct_top uut (.mclk, .sys_rst, .bus_addr, .bus_wr, .bus_rd, .bus_wdata, .bus_rdata, .sub_clk_pin,
    .event_input_pin, .event_edge_select, .upper_irq_enable, .lower_irq_enable, .upper_toggle_pin,
    .lower_toggle_pin, .upper_irq_req, .lower_irq_req);
  dmct_cpu_model cpu (.mclk, .bus_rdata, .bus_addr, .bus_wr, .bus_rd, .bus_wdata);

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Ticks expected from a lower select code over 256 cycles.
  function automatic int exp_ticks(input logic [2:0] c);
    return (c == TICK_D32 || c == TICK_SUB4) ? 8 : (c == TICK_D16) ? 16 : 64;
  endfunction

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    cpu.acc(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
    cpu.acc(1'b0, a, 8'h00, q);
    `CHK(q, e)
  endtask

  // Counts request pulses of one side over a bounded window.
  task automatic cnt_irq(input logic hi, input int lim, output int k);
    k = 0;
    repeat (lim) begin
      @(posedge mclk);
      #1 k += int'((hi ? upper_irq_req : lower_irq_req) === 1'b1);
    end
  endtask

  // Each level lasts at least two clocks.
  task automatic pulse();
    rnd = lfsr(rnd);
    event_input_pin = 1'b1;
    repeat (2 + rnd[1:0]) @(posedge mclk);
    #1 event_input_pin = 1'b0;
    repeat (2 + rnd[3:2]) @(posedge mclk);
    #1;
  endtask

  task automatic report_and_stop();
    if (bad_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    report_and_stop();
  end

  initial begin
    repeat (16) @(posedge mclk);
    #1 sys_rst = 1'b0;
    for (int i = 0; i < 8; i++) rd_chk(i[2:0], rstv[i]);
    wr(ADDR_CKSTP, 8'hFB);
    wr(ADDR_CTRL, 8'h06);
    cpu.wr16(ADDR_CNT_HI, 16'hAA55);
    repeat (40) @(posedge mclk);
    cpu.rd16(ADDR_CNT_HI, v);
    `CHK(v, 16'hAA55)
    rnd = lfsr(rnd);
    cpu.wr16(ADDR_CMP_HI, rnd);
    rd_chk(ADDR_CMP_LO, rnd[7:0]);
    rd_chk(ADDR_CMP_HI, rnd[15:8]);
    cpu.wr16(ADDR_CNT_HI, 16'h0000);
    cpu.wr16(ADDR_CMP_HI, 16'h0003);
    wr(ADDR_CSR, 8'h10);
    upper_irq_enable = 1'b1;
    wr(ADDR_CKSTP, 8'hFF);
    n = 0;
    while (upper_irq_req !== 1'b1 && n < 200) begin
      @(posedge mclk);
      #1 n++;
    end
    `CHK({upper_irq_req, upper_toggle_pin, lower_toggle_pin}, 3'h6)
    wr(ADDR_CKSTP, 8'hFB);
    cpu.acc(1'b0, ADDR_CSR, 8'h00, q);
    `CHK(q[CSR_MATCH_HI], 1'b1)
    cpu.rd16(ADDR_CNT_HI, v);
    `CHK(v < 16'h0004, 1'b1)
    upper_irq_enable = 1'b0;
    lower_irq_enable = 1'b1;
    wr(ADDR_CTRL, 8'h66);
    wr(ADDR_CNT_LO, 8'hFE);
    wr(ADDR_CMP_LO, 8'h01);
    cpu.acc(1'b0, ADDR_CSR, 8'h00, q);
    wr(ADDR_CSR, 8'h02);
    wr(ADDR_CKSTP, 8'hFF);
    cnt_irq(1'b0, 40, n);
    `CHK(n, 2)
    wr(ADDR_CKSTP, 8'hFB);
    `CHK(lower_toggle_pin, 1'b1)
    wr(ADDR_CSR, 8'h02);
    cpu.acc(1'b0, ADDR_CSR, 8'h00, q);
    `CHK(q[3:0], 4'hE)
    wr(ADDR_CSR, 8'h02);
    rd_chk(ADDR_CSR, 8'h02);
    wr(ADDR_CSR, 8'hFE);
    rd_chk(ADDR_CSR, 8'h32);
    wr(ADDR_CTRL, 8'hE6);
    `CHK({upper_toggle_pin, lower_toggle_pin}, 2'h2)
    for (int c = 4; c < 8; c++) begin
      wr(ADDR_CTRL, 8'h40 | c[7:0]);
      wr(ADDR_CNT_LO, 8'h00);
      wr(ADDR_CKSTP, 8'hFF);
      repeat (256) @(posedge mclk);
      wr(ADDR_CKSTP, 8'hFB);
      cpu.acc(1'b0, ADDR_CNT_LO, 8'h00, q);
      n = exp_ticks(c[2:0]);
      `CHK(q >= n - 1 && q <= n + 1, 1'b1)
    end
    wr(ADDR_CTRL, 8'h06);
    cpu.wr16(ADDR_CNT_HI, 16'hFFFE);
    wr(ADDR_CKSTP, 8'hFF);
    repeat (12) @(posedge mclk);
    wr(ADDR_CKSTP, 8'hFB);
    cpu.acc(1'b0, ADDR_CSR, 8'h00, q);
    `CHK(q[CSR_WRAP_HI], 1'b1)
    wr(ADDR_CTRL, 8'h40);
    wr(ADDR_CNT_LO, 8'h00);
    wr(ADDR_CMP_LO, 8'h03);
    wr(ADDR_CSR, 8'h33);
    wr(ADDR_CKSTP, 8'hFF);
    repeat (3) pulse();
    repeat (8) @(posedge mclk);
    #1 event_edge_select = 1'b0;
    repeat (2) pulse();
    repeat (8) @(posedge mclk);
    cpu.acc(1'b0, ADDR_CNT_LO, 8'h00, q);
    `CHK(q, 8'h01)
    report_and_stop();
  end
endmodule

`default_nettype wire
